// ---- verilog/ceq_pkg.sv ----
// package: register map, field layout and entry types for the error queue
package ceq_pkg;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] CONTROL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET  = 8'h04;
	localparam logic [7:0] HEAD_OFFSET    = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFFSET = 8'h0c;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;

	// ****************************************
	// field positions
	// ****************************************
	localparam int POP_BIT_POS      = 0;
	localparam int FLUSH_BIT_POS    = 1;
	localparam int OVF_CLR_BIT_POS  = 8;
	localparam int OVF_FLAG_POS     = 8;
	localparam int COUNT_LSB        = 0;
	localparam int COUNT_W          = 5;
	localparam int IRQ_PUSH_POS     = 0;
	localparam int IRQ_OVF_POS      = 1;
	localparam int IRQ_W            = 2;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [1:0]  IRQ_RESET = 2'h0;

	// ****************************************
	// entry layout
	// ****************************************
	localparam int QUEUE_DEPTH = 16;

	typedef enum logic [1:0] {
		CEQ_CAT0 = 2'b00,
		CEQ_CAT1 = 2'b01,
		CEQ_CAT2 = 2'b10,
		CEQ_CAT3 = 2'b11
	} ceq_cat_e;

	typedef struct packed {
		logic [7:0]  entry_error_code;
		logic [23:0] info;
	} ceq_entry_s;

	typedef struct packed {
		logic        valid;
		ceq_cat_e    cat;
		logic [7:0]  category_error_code;
		logic [7:0]  active_config_id;
		logic [7:0]  buffer_config_id;
	} ceq_event_s;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} ceq_bus_s;

endpackage

// ---- verilog/ceq_entry_fmt.sv ----
// entry formatter: builds a queue entry from an error event
`timescale 1ns/1ps
module ceq_entry_fmt (
	input  wire ceq_pkg::ceq_event_s ev_i,
	input  wire logic [23:0]         frame_cnt_i,
	output ceq_pkg::ceq_entry_s      entry_o
);

	always_comb begin
		entry_o.entry_error_code = ev_i.category_error_code;
		entry_o.info             = 24'h00_0000;
		case (ev_i.cat)
			// R10: frame counter
			ceq_pkg::CEQ_CAT1: begin
				entry_o.info = frame_cnt_i;
			end
			// R11: config ids
			ceq_pkg::CEQ_CAT2: begin
				entry_o.info = {8'h00, ev_i.active_config_id, ev_i.buffer_config_id};
			end
			// cat0 and cat3 zero info
			default: begin
				entry_o.info = 24'h00_0000;
			end
		endcase
	end

endmodule

// ---- verilog/ceq_frame_counter.sv ----
// free-running frame counter
`timescale 1ns/1ps
module ceq_frame_counter #(
	parameter int WIDTH = 24
) (
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             frame_tick_i,
	output logic      [WIDTH-1:0] count_o
);

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (frame_tick_i) begin
			count_next = count_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign count_o = count_reg;

endmodule

// ---- verilog/ceq_top.sv ----
// channel error queue: fifo of error entries with register access
// Notes on behaviour
// R01: writing one to bit 8 clears overflow
// R02: writing one to bit 1 flushes queue
// R03: writing one to bit 0 pops head
// R04: action bits always read as zero
// R05: dropped entry sets overflow status bit 8
// R06: overflow stays set until explicit clear
// R07: reads and pops never clear overflow
// R08: status bits 4..0 give unread count
// R09: head register shows oldest code and info
// R10: category 1 info holds frame counter
// R11: category 2 info holds both config ids
// R12: fifo order, count follows pop and clear
`timescale 1ns/1ps
module ceq_top #(
	parameter int DEPTH = ceq_pkg::QUEUE_DEPTH
) (
	input  wire  logic                clk_i,
	input  wire  logic                sys_rst_i,
	input  wire  logic [7:0]          addr_i,
	input  wire  logic [31:0]         wdata_i,
	input  wire  logic                wr_i,
	input  wire  logic                rd_i,
	output logic       [31:0]         rdata_o,
	input  wire  ceq_pkg::ceq_event_s err_event_i,
	input  wire  logic                frame_tick_i,
	output logic                      irq_o
);

	// ****************************************
	// state
	// ****************************************
	localparam int PW      = $clog2(DEPTH);
	localparam int COUNT_W = ceq_pkg::COUNT_W;

	typedef struct packed {
		ceq_pkg::ceq_entry_s [DEPTH-1:0] mem;
		logic [PW-1:0]                   head;
		logic [PW-1:0]                   tail;
		logic [ceq_pkg::COUNT_W-1:0]     count;
		logic                            ovf;
		logic [ceq_pkg::IRQ_W-1:0]       irq_stat;
		logic [ceq_pkg::IRQ_W-1:0]       irq_mask;
		logic [31:0]                     rdata;
	} ceq_state_s;

	ceq_state_s          st_reg;
	ceq_state_s          st_next;
	ceq_pkg::ceq_bus_s   bus;
	ceq_pkg::ceq_entry_s new_entry;
	logic [23:0]         frame_cnt;

	assign bus.addr  = addr_i;
	assign bus.wdata = wdata_i;
	assign bus.wr    = wr_i;
	assign bus.rd    = rd_i;

	// ****************************************
	// helpers
	// ****************************************
	ceq_frame_counter #(
		.WIDTH(24)
	) u_frame_cnt (
		.clk_i        (clk_i),
		.sys_rst_i    (sys_rst_i),
		.frame_tick_i (frame_tick_i),
		.count_o      (frame_cnt)
	);

	ceq_entry_fmt u_fmt (
		.ev_i        (err_event_i),
		.frame_cnt_i (frame_cnt),
		.entry_o     (new_entry)
	);

	// ****************************************
	// next state
	// ****************************************
	logic ctl_wr;
	logic do_pop;
	logic do_flush;
	logic do_ovf_clr;
	logic full;
	logic do_push;
	logic drop;

	always_comb begin
		ctl_wr     = bus.wr && (bus.addr == ceq_pkg::CONTROL_OFFSET);
		do_pop     = ctl_wr && bus.wdata[ceq_pkg::POP_BIT_POS]
		             && (st_reg.count != '0);
		do_flush   = ctl_wr && bus.wdata[ceq_pkg::FLUSH_BIT_POS];
		do_ovf_clr = ctl_wr && bus.wdata[ceq_pkg::OVF_CLR_BIT_POS];
		// full frees on a pop or a flush in the same cycle
		full       = (st_reg.count == COUNT_W'(DEPTH)) && !do_pop && !do_flush;
		do_push    = err_event_i.valid && !full;
		drop       = err_event_i.valid && full;

		st_next = st_reg;
		// R02: flush discards all entries
		if (do_flush) begin
			st_next.head  = '0;
			st_next.tail  = '0;
			st_next.count = '0;
			if (do_push) begin
				st_next.mem[0] = new_entry;
				st_next.tail   = PW'(1);
				st_next.count  = COUNT_W'(1);
			end
		end else begin
			// R12: push at tail, pop at head
			if (do_push) begin
				st_next.mem[st_reg.tail] = new_entry;
				st_next.tail = (st_reg.tail == PW'(DEPTH - 1)) ? '0 : st_reg.tail + 1'b1;
			end
			// R03: pop removes oldest
			if (do_pop) begin
				st_next.head = (st_reg.head == PW'(DEPTH - 1)) ? '0 : st_reg.head + 1'b1;
			end
			case ({do_push, do_pop})
				2'b10: begin
					st_next.count = st_reg.count + 1'b1;
				end
				2'b01: begin
					st_next.count = st_reg.count - 1'b1;
				end
				default: begin
					st_next.count = st_reg.count;
				end
			endcase
		end

		// R01: explicit overflow clear
		if (do_ovf_clr) begin
			st_next.ovf = 1'b0;
		end
		// R05: lost entry sets overflow, wins over clear
		// R06: sticky until clear, R07: pops leave it
		if (drop) begin
			st_next.ovf = 1'b1;
		end

		// interrupt status, set wins over write-one-clear
		if (bus.wr && (bus.addr == ceq_pkg::IRQ_STAT_OFFSET)) begin
			st_next.irq_stat = st_reg.irq_stat & ~bus.wdata[ceq_pkg::IRQ_W-1:0];
		end
		if (do_push) begin
			st_next.irq_stat[ceq_pkg::IRQ_PUSH_POS] = 1'b1;
		end
		if (drop) begin
			st_next.irq_stat[ceq_pkg::IRQ_OVF_POS] = 1'b1;
		end
		if (bus.wr && (bus.addr == ceq_pkg::IRQ_MASK_OFFSET)) begin
			st_next.irq_mask = bus.wdata[ceq_pkg::IRQ_W-1:0];
		end

		// read data valid the cycle after the strobe only
		st_next.rdata = ceq_pkg::REG_RESET;
		if (bus.rd) begin
			if (bus.addr == ceq_pkg::CONTROL_OFFSET) begin
				// R04: action bits read zero
				st_next.rdata = ceq_pkg::REG_RESET;
			end else if (bus.addr == ceq_pkg::STATUS_OFFSET) begin
				// R08: count and overflow
				st_next.rdata[ceq_pkg::COUNT_LSB +: ceq_pkg::COUNT_W] = st_reg.count;
				st_next.rdata[ceq_pkg::OVF_FLAG_POS] = st_reg.ovf;
			end else if (bus.addr == ceq_pkg::HEAD_OFFSET) begin
				// R09: oldest entry, zero when empty
				if (st_reg.count != '0) begin
					st_next.rdata = st_reg.mem[st_reg.head];
				end
			end else if (bus.addr == ceq_pkg::IRQ_STAT_OFFSET) begin
				st_next.rdata[ceq_pkg::IRQ_W-1:0] = st_reg.irq_stat;
			end else if (bus.addr == ceq_pkg::IRQ_MASK_OFFSET) begin
				st_next.rdata[ceq_pkg::IRQ_W-1:0] = st_reg.irq_mask;
			end else begin
				st_next.rdata = ceq_pkg::REG_RESET;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_reg          <= '0;
			st_reg.irq_stat <= ceq_pkg::IRQ_RESET;
			st_reg.irq_mask <= ceq_pkg::IRQ_RESET;
			st_reg.rdata    <= ceq_pkg::REG_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o = st_reg.rdata;
	assign irq_o   = |(st_reg.irq_stat & st_reg.irq_mask);

endmodule

// ---- sim/ceq_top_asserts.sv ----
// checker: port-level properties of the error queue
`timescale 1ns/1ps
module ceq_top_asserts #(
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire ceq_pkg::ceq_event_s err_event_i,
	input wire logic frame_tick_i,
	input wire logic irq_o
);
	logic st_rd_reg;
	logic ovf_seen_reg;
	wire ctl_wr = wr_i && addr_i == 8'h00;
	wire st_rd = rd_i && addr_i == 8'h04;
	wire no_ev = !err_event_i.valid;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// remembers a flag seen set by a status read
	always_ff @(posedge clk_i) begin
		st_rd_reg <= st_rd;
		if (sys_rst_i || (ctl_wr && wdata_i[8]))
			ovf_seen_reg <= 1'b0;
		else if (st_rd_reg && rdata_o[8])
			ovf_seen_reg <= 1'b1;
	end
	ctl_zero_a: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 32'h0)
		else $error("control read not zero");
	stat_resv_a: assert property (st_rd |=> rdata_o[31:9] == 0 && rdata_o[7:5] == 0)
		else $error("status spare bits set");
	cnt_bound_a: assert property (st_rd |=> rdata_o[4:0] <= DEPTH)
		else $error("count above depth");
	ovf_sticky_a: assert property (st_rd && ovf_seen_reg |=> rdata_o[8])
		else $error("overflow lost");
	ovf_clear_a: assert property (ctl_wr && wdata_i[8] && no_ev ##1 st_rd |=> !rdata_o[8])
		else $error("overflow not cleared");
	flush_a: assert property (ctl_wr && wdata_i[1] && no_ev ##1 st_rd |=> rdata_o[4:0] == 0)
		else $error("flush left entries");
	idle_zero_a: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data outside read");
	irq_hold_a: assert property (!rd_i && !wr_i && no_ev && !frame_tick_i |=> $stable(irq_o))
		else $error("irq moved while idle");
	cover property (st_rd ##1 rdata_o[8]);
	cover property (ctl_wr && wdata_i[1]);
	cover property ($rose(irq_o));
endmodule

bind ceq_top ceq_top_asserts #(.DEPTH(DEPTH)) ceq_top_asserts_inst (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .err_event_i(err_event_i), .frame_tick_i(frame_tick_i), .irq_o(irq_o));

// ---- sim/test_channel_error_queue.sv ----
// testbench: register-level scenarios for the error queue
`timescale 1ns/1ps
module test_channel_error_queue;
	localparam int DEPTH = 4;
	logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, frame_tick_i = 0, irq_o;
	logic [7:0] addr_i = 0;
	logic [31:0] wdata_i = 0, rdata_o;
	ceq_pkg::ceq_event_s err_event_i = '0;
	int miscompares = 0, n_checks = 0, cyc = 0;
	ceq_top #(.DEPTH(DEPTH)) ceq_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.err_event_i(err_event_i), .frame_tick_i(frame_tick_i), .irq_o(irq_o));
	initial forever #20 clk_i = ~clk_i;
	// hang guard
	always @(posedge clk_i) if (++cyc == 3000) begin
		miscompares++;
		summarize();
	end
	task automatic chk(string n, logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		if (wr_i) @(posedge clk_i);
		wr_i <= 1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 0;
	endtask
	task automatic rc(logic [7:0] a, logic [31:0] e);
		rd_i <= 1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 0;
		#1 chk($sformatf("reg %h", a), rdata_o, e);
		@(posedge clk_i);
	endtask
	task automatic ev(ceq_pkg::ceq_cat_e c, logic [7:0] k, a, b);
		if (err_event_i.valid) @(posedge clk_i);
		err_event_i <= '{1'b1, c, k, a, b};
		@(posedge clk_i);
		err_event_i.valid <= 0;
	endtask
	task automatic ci(logic e);
		@(negedge clk_i) chk("irq", 32'(irq_o), 32'(e));
		@(posedge clk_i);
	endtask
	task automatic t_fmt();
		frame_tick_i <= 1;
		repeat (5) @(posedge clk_i);
		frame_tick_i <= 0;
		ev(ceq_pkg::CEQ_CAT1, 8'h11, 8'h00, 8'h00);
		ev(ceq_pkg::CEQ_CAT2, 8'h22, 8'ha5, 8'h3c);
		ev(ceq_pkg::CEQ_CAT0, 8'h33, 8'hff, 8'hff);
		rc(8'h04, 32'h0000_0003);
		rc(8'h08, 32'h1100_0005);
		wr(8'h00, 32'h0000_0001);
		rc(8'h08, 32'h2200_a53c);
		wr(8'h00, 32'h0000_0001);
		rc(8'h08, 32'h3300_0000);
		wr(8'h00, 32'h0000_0001);
		rc(8'h04, 32'h0000_0000);
		rc(8'h08, 32'h0000_0000);
		$display("t_fmt done");
	endtask
	task automatic t_ovf();
		for (int i = 0; i <= DEPTH; i++) ev(ceq_pkg::CEQ_CAT0, 8'(i), 8'h00, 8'h00);
		rc(8'h04, 32'h0000_0104);
		wr(8'h00, 32'h0000_0001);
		rc(8'h04, 32'h0000_0103);
		rc(8'h08, 32'h0100_0000);
		wr(8'h00, 32'hffff_fefc);
		rc(8'h00, 32'h0000_0000);
		rc(8'h04, 32'h0000_0103);
		wr(8'h00, 32'h0000_0100);
		rc(8'h04, 32'h0000_0003);
		wr(8'h00, 32'h0000_0002);
		rc(8'h04, 32'h0000_0000);
		$display("t_ovf done");
	endtask
	task automatic t_irq();
		ci(1'b0);
		rc(8'h0c, 32'h0000_0003);
		wr(8'h10, 32'h0000_0003);
		ci(1'b1);
		wr(8'h0c, 32'h0000_0003);
		ci(1'b0);
		ev(ceq_pkg::CEQ_CAT0, 8'h44, 8'h00, 8'h00);
		ci(1'b1);
		wr(8'h10, 32'h0000_0002);
		ci(1'b0);
		wr(8'h40, 32'hffff_ffff);
		rc(8'h40, 32'h0000_0000);
		$display("t_irq done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 0;
		t_fmt();
		t_ovf();
		t_irq();
		summarize();
	end
endmodule
